// file: shared/fcc_regs.svh
// register map, field positions, reset values and timing figures of the charger control block
`ifndef FCC_REGS_SVH
`define FCC_REGS_SVH

`define FCC_ADDR_IRQ_STATUS 8'h06
`define FCC_ADDR_CONTROL 8'h07
`define FCC_ADDR_INTERVAL 8'h08
`define FCC_ADDR_DURATION 8'h09
`define FCC_ADDR_PULSE_LEN 8'h0a

`define FCC_CTRL_RUN 0
`define FCC_CTRL_ARMED 1
`define FCC_CTRL_STROBE 2
`define FCC_CTRL_REFILL 3
`define FCC_IRQ_TIMEOUT 3
`define FCC_IRQ_ARMED 6

`define FCC_PERIOD_RST 3'h1
`define FCC_DUR_RST 8'h00
`define FCC_DUR_START 8'h01
`define FCC_DUR_LAST 8'hfe
`define FCC_DUR_MAX 8'hff
`define FCC_PERIOD_BASE 4'h2

`define FCC_CLK_KHZ 200000
`define FCC_CLK_NS 5
`define FCC_DUR_STEP_MS 20
`define FCC_HALF_SEC_MS 500
`define FCC_PULSE_STEP_NS 1000

`endif

// file: shared/fcc_pkg.sv
// types shared by the charger control block
package fcc_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fcc_reg_req_t;

  typedef enum logic [1:0] {
    FCC_IDLE = 2'b01,
    FCC_CHARGE = 2'b10
  } fcc_state_t;

  typedef struct packed {
    logic gate_supply_on;
    logic lamp_strobe_supply_on;
  } fcc_supply_t;

endpackage : fcc_pkg

// file: src/fcc_charger_regs.sv
// charger control registers, refill timer, duration timer and test pulse
// Functional notes
// - status bits marked read-self-clear clear when the host reads their register
// - writing one to run bit 0 starts charging; bit resets to zero
// - writing zero to run bit stops charging; bit reads one while charging
// - armed bit 1 reads one after charge completes; a flash strobe clears it
// - strobe bit 2 written zero lets the gate drive follow the strobe pin
// - strobe bit written one fires one test pulse of the pulse-length register
// - reading strobe bit returns strobe pin level; valid only with a supply flag
// - gate supply set during and after charging; lamp supply set in lamp mode
// - refill enable bit 3 turns periodic recharge on or off; resets zero
// - period code 000 is 1.0 s, each step adds 0.5 s; resets to 001
// - first refill interval may be short due to a free-running timer
// - refill period runs from one recharge start to the next start
// - duration register resets 00h, holds last charge time, valid while armed
// - code 00h never started; code n spans (n-1)*20 ms to n*20 ms
// - code ffh means over 5080 ms and coincides with the timeout fault
// - reading interrupt status resets duration; host reads duration first
// - timeout fault sets status bit 3 at 06h and asserts active-low interrupt
// - charge completion sets armed flag bit 6 and signals an interrupt
// - test pulse length from register 0ah in 1 us steps; code 00h unused
`timescale 1ns/100ps
`include "fcc_regs.svh"

module fcc_charger_regs #(
  parameter int DUR_STEP_CYC = `FCC_DUR_STEP_MS * `FCC_CLK_KHZ,
  parameter int HALF_SEC_CYC = `FCC_HALF_SEC_MS * `FCC_CLK_KHZ
) (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic rstn, // synchronous reset, active low
  input wire fcc_pkg::fcc_reg_req_t reg_req, // register access from the serial slave
  output logic [7:0] reg_rdata, // read data, one cycle after rd
  input wire logic strobe_pin, // external strobe input
  input wire logic end_of_charge, // analog end-of-charge detect
  input wire logic lamp_strobe_mode, // lamp strobe mode selected
  input wire logic [7:0] pulse_len_nvm, // stored test pulse length
  output logic charger_on, // enables the charger
  output logic gate_drive, // flash gate drive
  output fcc_pkg::fcc_supply_t supply, // supply flags
  output logic timeout_fault_flag, // sticky timeout flag
  output logic armed_irq_flag, // sticky charge-done flag
  output logic int_n_o, // interrupt pin output level
  output logic int_n_oe // interrupt pin pulls low while high
);
  import fcc_pkg::*;

  localparam int PULSE_STEP_CYC = `FCC_PULSE_STEP_NS / `FCC_CLK_NS;
  localparam int DW = $clog2(DUR_STEP_CYC + 1);
  localparam int HW = $clog2(HALF_SEC_CYC + 1);
  localparam int PW = $clog2(PULSE_STEP_CYC + 1);

  fcc_state_t state_q;
  logic armed_q, refill_en_q, test_q, gate_q, gate_supply_q;
  logic [2:0] period_q;
  logic [7:0] dur_q, pulse_rem_q;
  logic [DW-1:0] dur_cnt_q;
  logic [HW-1:0] half_cnt_q;
  logic [PW-1:0] pre_cnt_q;
  logic [3:0] refill_age_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    hit = a == want;
  endfunction : hit

  logic wr_ctrl, rd_irq, charging, finish, timeout, dur_tick, half_tick, auto_start;
  logic start, stop, pulse_tick;
  logic [3:0] refill_target;

  assign wr_ctrl = reg_req.wr && hit(reg_req.addr, `FCC_ADDR_CONTROL);
  assign rd_irq = reg_req.rd && hit(reg_req.addr, `FCC_ADDR_IRQ_STATUS);
  assign charging = state_q == FCC_CHARGE;
  assign dur_tick = charging && dur_cnt_q == DW'(DUR_STEP_CYC - 1);
  assign half_tick = half_cnt_q == HW'(HALF_SEC_CYC - 1);
  assign finish = charging && end_of_charge;
  assign timeout = dur_tick && dur_q == `FCC_DUR_LAST && !end_of_charge;
  assign refill_target = {1'b0, period_q} + `FCC_PERIOD_BASE;
  assign auto_start = refill_en_q && !charging && refill_age_q >= refill_target;
  assign start = !charging && ((wr_ctrl && reg_req.wdata[`FCC_CTRL_RUN]) || auto_start);
  assign stop = charging && (finish || timeout || (wr_ctrl && !reg_req.wdata[`FCC_CTRL_RUN]));
  assign pulse_tick = pre_cnt_q == PW'(PULSE_STEP_CYC - 1);

  // charger run state; completion wins over a host stop in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= FCC_IDLE;
    end else if (stop) begin
      state_q <= FCC_IDLE;
    end else if (start) begin
      state_q <= FCC_CHARGE;
    end
  end

  assign charger_on = charging;

  // armed bit: set at completion, cleared by a rising gate drive edge or a charge start
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      armed_q <= 1'b0;
    end else if (finish) begin
      armed_q <= 1'b1;
    end else if (gate_drive && !gate_q || start) begin
      armed_q <= 1'b0;
    end
  end

  // refill enable and period are plain host settings
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      refill_en_q <= 1'b0;
      period_q <= `FCC_PERIOD_RST;
    end else begin
      if (wr_ctrl) begin
        refill_en_q <= reg_req.wdata[`FCC_CTRL_REFILL];
      end
      if (reg_req.wr && hit(reg_req.addr, `FCC_ADDR_INTERVAL)) begin
        period_q <= reg_req.wdata[2:0];
      end
    end
  end

  // free-running half-second timer; not restarted, so the first interval can be short
  always_ff @(posedge sys_clk) begin
    if (!rstn || half_tick) begin
      half_cnt_q <= '0;
    end else begin
      half_cnt_q <= half_cnt_q + HW'(1);
    end
  end

  // age since last recharge start, in half seconds; saturates at the target
  always_ff @(posedge sys_clk) begin
    if (!rstn || start) begin
      refill_age_q <= '0;
    end else if (half_tick && refill_age_q < refill_target) begin
      refill_age_q <= refill_age_q + 4'h1;
    end
  end

  // 20 ms prescaler, restarted with each charge so code 01h covers the first step
  always_ff @(posedge sys_clk) begin
    if (!rstn || start || dur_tick) begin
      dur_cnt_q <= '0;
    end else if (charging) begin
      dur_cnt_q <= dur_cnt_q + DW'(1);
    end
  end

  // duration code; frozen while idle, cleared by an interrupt status read
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dur_q <= `FCC_DUR_RST;
    end else if (start) begin
      dur_q <= `FCC_DUR_START;
    end else if (dur_tick && !finish && dur_q != `FCC_DUR_MAX) begin
      dur_q <= dur_q + 8'h01;
    end else if (rd_irq && !charging) begin
      dur_q <= `FCC_DUR_RST;
    end
  end

  // sticky flags; a set in the read cycle survives the self-clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timeout_fault_flag <= 1'b0;
      armed_irq_flag <= 1'b0;
    end else begin
      if (timeout) begin
        timeout_fault_flag <= 1'b1;
      end else if (rd_irq) begin
        timeout_fault_flag <= 1'b0;
      end
      if (finish) begin
        armed_irq_flag <= 1'b1;
      end else if (rd_irq) begin
        armed_irq_flag <= 1'b0;
      end
    end
  end

  assign int_n_o = 1'b0;
  assign int_n_oe = timeout_fault_flag || armed_irq_flag;

  // test pulse; code 00h gives no pulse, the host must not use it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      test_q <= 1'b0;
      pulse_rem_q <= 8'h00;
      pre_cnt_q <= '0;
    end else if (wr_ctrl) begin
      test_q <= reg_req.wdata[`FCC_CTRL_STROBE];
      pulse_rem_q <= reg_req.wdata[`FCC_CTRL_STROBE] ? pulse_len_nvm : 8'h00;
      pre_cnt_q <= '0;
    end else if (pulse_rem_q != 8'h00) begin
      pre_cnt_q <= pulse_tick ? '0 : pre_cnt_q + PW'(1);
      if (pulse_tick) begin
        pulse_rem_q <= pulse_rem_q - 8'h01;
      end
    end else begin
      test_q <= 1'b0; // after the pulse, control returns to the pin
    end
  end

  // gate drive registered so a strobe edge is seen one cycle later by the armed bit
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      gate_q <= 1'b0;
      gate_drive <= 1'b0;
    end else begin
      gate_drive <= test_q ? pulse_rem_q != 8'h00 : strobe_pin;
      gate_q <= gate_drive;
    end
  end

  // gate supply stays up once a charge has begun
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      gate_supply_q <= 1'b0;
    end else if (start) begin
      gate_supply_q <= 1'b1;
    end
  end

  assign supply.gate_supply_on = gate_supply_q;
  assign supply.lamp_strobe_supply_on = lamp_strobe_mode;

  // read mux; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      if (hit(reg_req.addr, `FCC_ADDR_IRQ_STATUS)) begin
        reg_rdata <= 8'h00;
        reg_rdata[`FCC_IRQ_TIMEOUT] <= timeout_fault_flag;
        reg_rdata[`FCC_IRQ_ARMED] <= armed_irq_flag;
      end else if (hit(reg_req.addr, `FCC_ADDR_CONTROL)) begin
        reg_rdata <= {4'h0, refill_en_q, strobe_pin, armed_q, charging};
      end else if (hit(reg_req.addr, `FCC_ADDR_INTERVAL)) begin
        reg_rdata <= {5'h00, period_q};
      end else if (hit(reg_req.addr, `FCC_ADDR_DURATION)) begin
        reg_rdata <= dur_q;
      end else if (hit(reg_req.addr, `FCC_ADDR_PULSE_LEN)) begin
        reg_rdata <= pulse_len_nvm;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  sequence host_run_write;
    wr_ctrl && reg_req.wdata[`FCC_CTRL_RUN] && !charging && !end_of_charge;
  endsequence

  sequence host_stop_write;
    wr_ctrl && !reg_req.wdata[`FCC_CTRL_RUN] && charging;
  endsequence

  run_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    host_run_write |=> charger_on && !armed_q && dur_q == `FCC_DUR_START)
    else $error("run write did not start charging");

  run_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    host_stop_write |=> !charger_on)
    else $error("stop write did not stop charging");

  eoc_arm_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    finish |=> armed_q && !charger_on && armed_irq_flag && int_n_oe)
    else $error("end of charge not reported");

  strobe_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(gate_drive) && !finish |=> !armed_q)
    else $error("strobe did not clear armed");

  pin_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !test_q && !wr_ctrl |=> gate_drive == $past(strobe_pin))
    else $error("gate drive not following strobe pin");

  test_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_ctrl && reg_req.wdata[`FCC_CTRL_STROBE] && pulse_len_nvm != 8'h00
      |=> ##1 gate_drive [*8])
    else $error("test pulse missing");

  timeout_code_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    timeout |=> dur_q == `FCC_DUR_MAX && timeout_fault_flag && !charger_on)
    else $error("timeout code or flag wrong");

  irq_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_irq && !charging && !finish && !start |=> !armed_irq_flag && dur_q == `FCC_DUR_RST)
    else $error("status read did not clear");

  interval_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_req.rd && hit(reg_req.addr, `FCC_ADDR_INTERVAL) |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved interval bits nonzero");

endmodule : fcc_charger_regs

// file: verification/fcc_host_model.sv
// host-side model that issues single-byte register requests to the charger block
`timescale 1ns/100ps
module fcc_host_model (
  input wire logic sys_clk, // bench clock
  output fcc_pkg::fcc_reg_req_t reg_req, // register requests
  input wire logic [7:0] reg_rdata // read data, valid the cycle after rd
);
  import fcc_pkg::*;
  int gap = 0; // extra idle edges after each request, zero answers promptly
  initial reg_req = '0;
  // requests start just after an edge and are released just after the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    #1 reg_req = '0;
    repeat (gap + 1) @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    #1 reg_req = '0;
    d = reg_rdata;
    repeat (gap + 1) @(posedge sys_clk);
    #1;
  endtask : rd
endmodule : fcc_host_model

// file: verification/flash_charger_control_regs_tb_top.sv
// self-checking bench for the charger control registers
`timescale 1ns/100ps
module flash_charger_control_regs_tb_top;
  import fcc_pkg::*;
  localparam int STEP = 20;
  localparam int HALF = 10;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic strobe_pin = 1'b0;
  logic end_of_charge = 1'b0;
  logic lamp_strobe_mode = 1'b0;
  logic [7:0] pulse_len_nvm = 8'h02;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic charger_on, gate_drive, timeout_fault_flag, armed_irq_flag, int_n_o, int_n_oe;
  logic on_q = 1'b0;
  logic [15:0] lfsr_q = 16'h000b;
  fcc_reg_req_t reg_req;
  fcc_supply_t supply;
  int fails = 0;
  int num_checks = 0;
  int starts = 0;
  int on_cyc = 0;
  int c, k, k0;

  always #2.5 sys_clk = ~sys_clk;

  // counts charge starts and the length of the current charge
  always @(posedge sys_clk) begin
    on_q <= charger_on;
    if (charger_on && !on_q) begin
      starts++;
      on_cyc = 1;
    end else if (charger_on) begin
      on_cyc++;
    end
  end

  fcc_charger_regs #(.DUR_STEP_CYC(STEP), .HALF_SEC_CYC(HALF)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .strobe_pin(strobe_pin), .end_of_charge(end_of_charge),
    .lamp_strobe_mode(lamp_strobe_mode), .pulse_len_nvm(pulse_len_nvm),
    .charger_on(charger_on), .gate_drive(gate_drive), .supply(supply),
    .timeout_fault_flag(timeout_fault_flag), .armed_irq_flag(armed_irq_flag),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe));

  fcc_host_model host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd

  // code n covers more than n-1 and at most n whole steps of charging
  function automatic logic [15:0] exp_dur(int cyc);
    return ((cyc + STEP - 1) / STEP > 254) ? 16'h00ff : 16'((cyc + STEP - 1) / STEP);
  endfunction : exp_dur

  task automatic chk(string n, logic [15:0] e, logic [15:0] g, int tol = 0);
    logic ok;
    ok = (g + tol >= e) && (g <= e + tol);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(logic [7:0] a, logic [7:0] e, string n, int tol = 0);
    host.rd(a, rv);
    chk(n, {8'h00, e}, {8'h00, rv}, tol);
  endtask : rdchk

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // whole run needs well under the 40000-cycle time limit
  initial begin
    #(5 * 40000);
    fails++;
    final_report();
  end

  initial begin
    cyc(12);
    rstn = 1'b1;
    rdchk(8'h07, 8'h00, "control");
    rdchk(8'h08, 8'h01, "interval");
    host.wr(8'h09, 8'h55);
    rdchk(8'h09, 8'h00, "duration");
    rdchk(8'h3c, 8'h00, "unmapped");
    k = rnd();
    host.wr(8'h08, k[7:0]);
    rdchk(8'h08, {5'h00, k[2:0]}, "interval rw");
    host.wr(8'h07, 8'hf0);
    rdchk(8'h07, 8'h00, "control upper");
    rdchk(8'h0a, pulse_len_nvm, "pulse len");
    host.gap = rnd() % 3;
    k = rnd() % 100 + 30;
    host.wr(8'h07, 8'h01);
    rdchk(8'h07, 8'h01, "running");
    cyc(k);
    end_of_charge = 1'b1;
    cyc(1);
    end_of_charge = 1'b0;
    chk("charger_on", 0, charger_on);
    chk("irq", 3, {armed_irq_flag, int_n_oe});
    chk("gate supply", 1, supply.gate_supply_on);
    rdchk(8'h09, 8'(exp_dur(on_cyc)), "duration");
    rdchk(8'h07, 8'h02, "armed");
    rdchk(8'h06, 8'h40, "status");
    rdchk(8'h09, 8'h00, "duration clr");
    rdchk(8'h06, 8'h00, "status clr");
    chk("int_n_oe", 0, int_n_oe);
    chk("int_n_o", 0, int_n_o);
    strobe_pin = 1'b1;
    cyc(2);
    chk("gate pin", 1, gate_drive);
    rdchk(8'h07, 8'h04, "strobe read");
    strobe_pin = 1'b0;
    cyc(2);
    chk("gate pin low", 0, gate_drive);
    host.wr(8'h07, 8'h01);
    host.wr(8'h07, 8'h00);
    chk("stopped", 0, charger_on);
    repeat (2) begin
      pulse_len_nvm = 8'(rnd() % 3 + 1);
      host.wr(8'h07, 8'h04);
      c = 0;
      while (gate_drive !== 1'b1 && c < 50) begin cyc(1); c++; end
      c = 0;
      while (gate_drive === 1'b1 && c < 2000) begin cyc(1); c++; end
      // counting starts gap cycles into the pulse, so allow that much short
      chk("pulse", 16'(pulse_len_nvm * 200), c[15:0], host.gap);
      host.wr(8'h07, 8'h00);
    end
    host.wr(8'h07, 8'h01);
    c = 0;
    while (charger_on !== 1'b0 && c < 6000) begin cyc(1); c++; end
    chk("timeout time", 254 * STEP, on_cyc[15:0]);
    chk("timeout flag", 1, timeout_fault_flag);
    chk("int_n_oe timeout", 1, int_n_oe);
    rdchk(8'h09, 8'hff, "duration max");
    rdchk(8'h06, 8'h08, "status timeout");
    for (int i = 0; i < 2; i++) begin
      lamp_strobe_mode = i[0];
      cyc(1);
      chk("lamp supply", i, supply.lamp_strobe_supply_on);
    end
    // end of charge held high so each refill charge lasts one cycle
    end_of_charge = 1'b1;
    k = rnd() % 3;
    host.wr(8'h08, k[7:0]);
    host.wr(8'h07, 8'h08);
    k0 = starts;
    c = 0;
    while (starts == k0 && c < 200) begin cyc(1); c++; end
    k0 = starts;
    c = 0;
    while (starts == k0 && c < 200) begin cyc(1); c++; end
    chk("refill gap", 16'((k + 2) * HALF), c[15:0], HALF + 1);
    // once synchronised to the timer, start-to-start spacing is exact
    k0 = starts;
    c = 0;
    while (starts == k0 && c < 200) begin cyc(1); c++; end
    chk("refill period", 16'((k + 2) * HALF), c[15:0]);
    host.wr(8'h07, 8'h00);
    k0 = starts;
    cyc(100);
    chk("refill off", k0, starts);
    end_of_charge = 1'b0;
    final_report();
  end
endmodule : flash_charger_control_regs_tb_top
